// File: core/pss_defs.svh
// Purpose: Shared constants for the pipelined synchronous SRAM port.
// Assumes: Included by the package, interface and both ends.
// Notes: Lane i of the word occupies bits [9i+8:9i]; bit 8 of each lane is parity.
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_ADDR_W    17
`define PSS_LANES     4
`define PSS_LANE_W    9
`define PSS_BURST_LEN 4
`define PSS_CNT_W     2
`define PSS_SCAN_W    1
`endif

// File: core/pss_pkg.sv
// Purpose: Types shared by both ends of the SRAM port.
// Assumes: pss_defs.svh holds the numeric constants.
// Notes: None.
`include "pss_defs.svh"
package pss_pkg;
  typedef enum logic [1:0] {PSS_OP_NONE, PSS_OP_READ, PSS_OP_WRITE} pss_op_t;
endpackage

// File: core/pss_if.sv
// Purpose: Pin-level link between memory controller and SRAM device.
// Assumes: One clock shared by both ends.
// Notes: The shared data wire is resolved here from the two drive enables.
`timescale 1ns/10ps
`include "pss_defs.svh"
interface pss_if #(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_W
);
  localparam int DW = LANES * LANE_W;
  logic [ADDR_W-1:0] addr_in;
  logic              load_advance;
  logic              cycle_hold_n;
  logic              chip_select_low_a;
  logic              chip_select_pair;
  logic              chip_select_low_b;
  logic              read_write_sel;
  logic [LANES-1:0]  byte_write_n;
  logic              burst_order_sel;
  logic              bus_drive_enable_n;
  logic [DW-1:0]     data_lane_dev;
  logic              data_lane_dev_oe;
  logic [DW-1:0]     data_lane_ctl;
  logic              data_lane_ctl_oe;
  logic [DW-1:0]     data_lane;
  logic              test_clk;
  logic              test_mode;
  logic              test_din;
  logic              test_dout;
  logic              test_dout_oe;

  // Undriven bus reads as all zeros
  assign data_lane = data_lane_dev_oe ? data_lane_dev :
                     data_lane_ctl_oe ? data_lane_ctl : {DW{1'b0}};

  modport dev (
    input  addr_in, load_advance, cycle_hold_n, chip_select_low_a, chip_select_pair,
    input  chip_select_low_b, read_write_sel, byte_write_n, burst_order_sel,
    input  bus_drive_enable_n, data_lane, test_clk, test_mode, test_din,
    output data_lane_dev, data_lane_dev_oe, test_dout, test_dout_oe
  );
  modport ctl (
    output addr_in, load_advance, cycle_hold_n, chip_select_low_a, chip_select_pair,
    output chip_select_low_b, read_write_sel, byte_write_n, burst_order_sel,
    output bus_drive_enable_n, data_lane_ctl, data_lane_ctl_oe,
    output test_clk, test_mode, test_din,
    input  data_lane, test_dout, test_dout_oe
  );
endinterface

// File: core/pss_sram_end.sv
// Purpose: Device end of the pipelined synchronous SRAM port.
// Assumes: Link pins sampled on clk_in rising edge, except bus_drive_enable_n, which gates the data drive directly; test clock is a sampled input.
// Notes: Access issued at edge n transfers data at edge n+2.
// Operation
// RULE_01: Load address only when selected, loading, not held
// RULE_02: Load while deselected ends any running burst
// RULE_03: Advance steps burst counter, ignores address pins
// RULE_04: Load classifies read/write; data two cycles later
// RULE_05: Hold freezes every register and output; the test port registers keep running during hold
// RULE_06: One active-low write enable per 9-bit lane
// RULE_07: Controller supplies lane enables on every write cycle
// RULE_08: Lane enables ignored on read cycles
// RULE_09: Enabled lanes stored two cycles after issue
// RULE_10: Deselect tri-states data bus two cycles later
// RULE_11: Active-high select mirrors the active-low selects
// RULE_12: All synchronous pins use the rising clock
// RULE_13: Write and read data pass through registers
// RULE_14: Order select high interleaved, low linear
// RULE_15: Order select stays fixed during operation
// RULE_16: Drive enable high forces bus to high impedance
// RULE_17: Drive enable may simply be tied low
// RULE_18: Lane enables may be tied low for full words
// RULE_19: Test mode sampled on test clock rise
// RULE_20: Test data shifted in on test clock rise
// RULE_21: Test inputs on rise, outputs on fall
// RULE_22: Burst gives at most four words per address
// RULE_23: Counter works on two low address bits
`timescale 1ns/10ps
`include "pss_defs.svh"
module pss_sram_end
  import pss_pkg::*;
#(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_W,
  parameter int SCAN_W = `PSS_SCAN_W
)(
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  pss_if.dev        link,
  output logic      burst_active_out,
  output logic      selected_out
);
  localparam int DW = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Next burst offset from start value and count
  function automatic logic [`PSS_CNT_W-1:0] burst_lsb(
    input logic [`PSS_CNT_W-1:0] start,
    input logic [`PSS_CNT_W-1:0] cnt,
    input logic                  interleave
  );
    if (interleave)
    begin
      return start ^ cnt; // RULE_14 RULE_23
    end
    return start + cnt; // RULE_23
  endfunction

  logic [DW-1:0]           mem_q [DEPTH];
  pss_op_t                 burst_op_q;
  logic [ADDR_W-1:0]       base_q;
  logic [`PSS_CNT_W-1:0]   cnt_q;
  pss_op_t                 s1_op_q;
  logic [ADDR_W-1:0]       s1_addr_q;
  logic [LANES-1:0]        s1_bw_n_q;
  pss_op_t                 s2_op_q;
  logic [ADDR_W-1:0]       s2_addr_q;
  logic [LANES-1:0]        s2_bw_n_q;
  logic [DW-1:0]           rdata_q;
  logic                    sel;
  logic                    run;
  pss_op_t                 iss_op;
  logic [ADDR_W-1:0]       iss_addr;
  logic [`PSS_CNT_W-1:0]   nxt_cnt;
  logic [DW-1:0]           merged;
  logic [DW-1:0]           fwd;
  logic                    tck_q;
  logic                    tms_q;
  logic [SCAN_W-1:0]       scan_q;
  logic                    tdo_q;
  logic                    tdo_oe_q;
  logic                    tck_rise;
  logic                    tck_fall;

  assign sel = !link.chip_select_low_a && link.chip_select_pair
               && !link.chip_select_low_b; // RULE_11
  assign run = !link.cycle_hold_n ? 1'b1 : 1'b0; // RULE_05

  // Work out what this edge issues
  always_comb
  begin
    iss_op   = PSS_OP_NONE;
    iss_addr = base_q;
    nxt_cnt  = cnt_q;
    if (!link.load_advance)
    begin
      if (sel)
      begin
        iss_op   = link.read_write_sel ? PSS_OP_READ : PSS_OP_WRITE; // RULE_04
        iss_addr = link.addr_in; // RULE_01
        nxt_cnt  = '0;
      end
    end
    else if (burst_op_q != PSS_OP_NONE
             && cnt_q != `PSS_CNT_W'(`PSS_BURST_LEN - 1)) // RULE_22
    begin
      nxt_cnt  = cnt_q + 1'b1; // RULE_03
      iss_op   = burst_op_q;
      iss_addr = {base_q[ADDR_W-1:`PSS_CNT_W],
                  burst_lsb(base_q[`PSS_CNT_W-1:0], nxt_cnt, link.burst_order_sel)};
    end
  end

  // Burst state
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      burst_op_q <= PSS_OP_NONE;
      base_q     <= '0;
      cnt_q      <= '0;
    end
    else if (run)
    begin
      if (!link.load_advance)
      begin
        burst_op_q <= iss_op; // RULE_02 RULE_10
        cnt_q      <= '0;
        if (sel)
        begin
          base_q <= link.addr_in; // RULE_01
        end
      end
      else if (iss_op != PSS_OP_NONE)
      begin
        cnt_q <= nxt_cnt; // RULE_03
      end
      else
      begin
        burst_op_q <= PSS_OP_NONE; // RULE_22
      end
    end
  end

  // Two-stage access pipeline
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_op_q   <= PSS_OP_NONE;
      s1_addr_q <= '0;
      s1_bw_n_q <= '1;
      s2_op_q   <= PSS_OP_NONE;
      s2_addr_q <= '0;
      s2_bw_n_q <= '1;
    end
    else if (run) // RULE_05
    begin
      s1_op_q   <= iss_op;
      s1_addr_q <= iss_addr;
      s1_bw_n_q <= (iss_op == PSS_OP_WRITE) ? link.byte_write_n : '1; // RULE_08 RULE_07
      s2_op_q   <= s1_op_q; // RULE_04 RULE_10
      s2_addr_q <= s1_addr_q;
      s2_bw_n_q <= s1_bw_n_q;
    end
  end

  // Incoming lanes merged over stored word, per lane
  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
      assign merged[g*LANE_W +: LANE_W] = s2_bw_n_q[g] ? mem_q[s2_addr_q][g*LANE_W +: LANE_W]
                                          : link.data_lane[g*LANE_W +: LANE_W]; // RULE_06
    end
  endgenerate

  // Write-then-read to one address sees the new data
  always_comb
  begin
    fwd = mem_q[s1_addr_q];
    if (s2_op_q == PSS_OP_WRITE && s2_addr_q == s1_addr_q)
    begin
      fwd = merged;
    end
  end

  // Array store of the registered input lanes
  always_ff @(posedge clk_in)
  begin
    if (run && s2_op_q == PSS_OP_WRITE)
    begin
      mem_q[s2_addr_q] <= merged; // RULE_09 RULE_13
    end
  end

  // Output data register
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_q <= '0;
    end
    else if (run && s1_op_q == PSS_OP_READ)
    begin
      rdata_q <= fwd; // RULE_13 RULE_12
    end
  end

  assign link.data_lane_dev    = rdata_q;
  assign link.data_lane_dev_oe = (s2_op_q == PSS_OP_READ)
                                 && !link.bus_drive_enable_n; // RULE_16 RULE_10
  assign burst_active_out      = (burst_op_q != PSS_OP_NONE);
  assign selected_out          = (s2_op_q != PSS_OP_NONE);

  // Test port edges seen through the system clock
  assign tck_rise = link.test_clk && !tck_q;
  assign tck_fall = !link.test_clk && tck_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tck_q  <= 1'b0;
      tms_q  <= 1'b1;
      scan_q <= '0;
    end
    else
    begin
      tck_q <= link.test_clk;
      if (tck_rise)
      begin
        tms_q <= link.test_mode; // RULE_19 RULE_21
        if (!link.test_mode)
        begin
          // Shift right, new bit entering at the top
          scan_q <= SCAN_W'({link.test_din, scan_q} >> 1); // RULE_20
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_q    <= scan_q[0]; // RULE_21
      tdo_oe_q <= !tms_q;
    end
  end

  assign link.test_dout    = tdo_q;
  assign link.test_dout_oe = tdo_oe_q;
endmodule

// File: core/pss_ctrl_end.sv
// Purpose: Controller end driving the pipelined synchronous SRAM port.
// Assumes: Command and data pins driven from flops; the device samples them next edge. Outgoing test pins pass straight through; test_dout_oe gates test_dout.
// Notes: Selects beyond the first are tied to their selected level.
`timescale 1ns/10ps
`include "pss_defs.svh"
module pss_ctrl_end
  import pss_pkg::*;
#(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_W
)(
  input  wire logic                    clk_in,
  input  wire logic                    arst_n_in,
  pss_if.ctl                           link,
  input  wire logic                    req_valid_in,
  input  wire logic                    req_advance_in,
  input  wire logic                    req_write_in,
  input  wire logic [ADDR_W-1:0]       req_addr_in,
  input  wire logic [LANES*LANE_W-1:0] req_wdata_in,
  input  wire logic [LANES-1:0]        req_byte_write_n_in,
  input  wire logic                    hold_in,
  input  wire logic                    order_sel_in,
  input  wire logic                    test_clk_in,
  input  wire logic                    test_mode_in,
  input  wire logic                    test_din_in,
  output logic                         req_ready_out,
  output logic                         rsp_valid_out,
  output logic [LANES*LANE_W-1:0]      rsp_rdata_out,
  output logic                         test_dout_out
);
  localparam int DW = LANES * LANE_W;

  logic [ADDR_W-1:0]     addr_q;
  logic                  ld_adv_q;
  logic                  hold_n_q;
  logic                  cs_n_q;
  logic                  rw_q;
  logic [LANES-1:0]      bw_n_q;
  logic [DW-1:0]         wdata_q;
  pss_op_t               cmd_op_q;
  pss_op_t               burst_op_q;
  logic [`PSS_CNT_W-1:0] cnt_q;
  pss_op_t               p1_op_q;
  logic [DW-1:0]         p1_data_q;
  pss_op_t               p2_op_q;
  logic [DW-1:0]         p2_data_q;
  logic                  rsp_valid_q;
  logic [DW-1:0]         rsp_data_q;
  logic                  order_q;
  logic                  consume;
  logic                  can_adv;

  assign req_ready_out = !hold_in;
  assign consume       = !hold_n_q;
  assign can_adv       = burst_op_q != PSS_OP_NONE
                         && cnt_q != `PSS_CNT_W'(`PSS_BURST_LEN - 1);

  // Command registers toward the pins
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      addr_q     <= '0;
      ld_adv_q   <= 1'b0;
      hold_n_q   <= 1'b0;
      cs_n_q     <= 1'b1;
      rw_q       <= 1'b1;
      bw_n_q     <= '1;
      wdata_q    <= '0;
      cmd_op_q   <= PSS_OP_NONE;
      burst_op_q <= PSS_OP_NONE;
      cnt_q      <= '0;
    end
    else
    begin
      hold_n_q <= hold_in;
      if (!hold_in)
      begin
        addr_q   <= req_addr_in;
        wdata_q  <= req_wdata_in;
        ld_adv_q <= req_valid_in && req_advance_in;
        cs_n_q   <= !(req_valid_in && !req_advance_in);
        rw_q     <= !req_write_in;
        bw_n_q   <= req_write_in ? req_byte_write_n_in : '1; // RULE_07 RULE_18
        if (req_valid_in && req_advance_in)
        begin
          cmd_op_q <= can_adv ? burst_op_q : PSS_OP_NONE;
          cnt_q    <= can_adv ? cnt_q + 1'b1 : cnt_q;
        end
        else
        begin
          cmd_op_q   <= !req_valid_in ? PSS_OP_NONE
                        : req_write_in ? PSS_OP_WRITE : PSS_OP_READ;
          burst_op_q <= !req_valid_in ? PSS_OP_NONE
                        : req_write_in ? PSS_OP_WRITE : PSS_OP_READ;
          cnt_q      <= '0;
        end
      end
    end
  end

  // Burst order is retaken on every unheld edge with no command or burst open
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      order_q <= 1'b0;
    end
    else if (!hold_n_q && cmd_op_q == PSS_OP_NONE && burst_op_q == PSS_OP_NONE)
    begin
      order_q <= order_sel_in; // RULE_15
    end
  end

  // Data phase two edges after the device takes the command
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      p1_op_q     <= PSS_OP_NONE;
      p1_data_q   <= '0;
      p2_op_q     <= PSS_OP_NONE;
      p2_data_q   <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      if (consume)
      begin
        p1_op_q   <= cmd_op_q;
        p1_data_q <= wdata_q;
        p2_op_q   <= p1_op_q;
        p2_data_q <= p1_data_q;
        if (p2_op_q == PSS_OP_READ)
        begin
          rsp_valid_q <= 1'b1;
          rsp_data_q  <= link.data_lane;
        end
      end
    end
  end

  assign link.addr_in            = addr_q;
  assign link.load_advance       = ld_adv_q;
  assign link.cycle_hold_n       = hold_n_q;
  assign link.chip_select_low_a  = cs_n_q;
  assign link.chip_select_pair   = 1'b1;
  assign link.chip_select_low_b  = 1'b0;
  assign link.read_write_sel     = rw_q;
  assign link.byte_write_n       = bw_n_q;
  assign link.burst_order_sel    = order_q;
  assign link.bus_drive_enable_n = 1'b0; // RULE_17
  assign link.data_lane_ctl      = p2_data_q;
  assign link.data_lane_ctl_oe   = (p2_op_q == PSS_OP_WRITE);
  assign link.test_clk           = test_clk_in;
  assign link.test_mode          = test_mode_in;
  assign link.test_din           = test_din_in;
  assign rsp_valid_out           = rsp_valid_q;
  assign rsp_rdata_out           = rsp_data_q;
  assign test_dout_out           = link.test_dout_oe ? link.test_dout : 1'b0;
endmodule

// File: dv/pss_port_properties.sv
// Purpose: Pin-level checks on the link between the two ends.
// Assumes: One clock; reset asynchronous, active low.
// Notes: words_q follows the burst position seen on the pins.
`timescale 1ns/10ps
`include "pss_defs.svh"
module pss_port_properties #(
  parameter int DW = `PSS_LANES * `PSS_LANE_W
)(
  input wire logic          clk_in,
  input wire logic          arst_n_in,
  input wire logic          load_advance,
  input wire logic          cycle_hold_n,
  input wire logic          chip_select_low_a,
  input wire logic          chip_select_pair,
  input wire logic          chip_select_low_b,
  input wire logic          read_write_sel,
  input wire logic [DW-1:0] data_lane_dev,
  input wire logic          data_lane_dev_oe,
  input wire logic          data_lane_ctl_oe,
  input wire logic          test_clk,
  input wire logic          test_dout,
  input wire logic          test_dout_oe
);
  logic       sel;
  logic       go;
  logic [2:0] words_q;
  logic       rd_q;
  assign sel = !chip_select_low_a && chip_select_pair && !chip_select_low_b;
  assign go  = !cycle_hold_n && !load_advance;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      words_q <= 3'h0;
    else if (go)
      words_q <= sel ? 3'h1 : 3'h0;
    else if (!cycle_hold_n)
      words_q <= (words_q == 3'h0 || words_q == 3'h4) ? 3'h0 : words_q + 3'h1;
  end
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_q <= 1'b0;
    else if (go && sel)
      rd_q <= read_write_sel;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_read_issue;
    go && sel && read_write_sel ##1 !cycle_hold_n |=> data_lane_dev_oe && !data_lane_ctl_oe;
  endproperty
  a_read_issue: assert property (p_read_issue) else $error("read not driven");
  property p_write_issue;
    go && sel && !read_write_sel ##1 !cycle_hold_n |=> data_lane_ctl_oe && !data_lane_dev_oe;
  endproperty
  a_write_issue: assert property (p_write_issue) else $error("write slot wrong");
  property p_deselect;
    go && !sel ##1 !cycle_hold_n |=> !data_lane_dev_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("bus not released");
  property p_burst_step;
    !cycle_hold_n && load_advance && rd_q && words_q inside {3'h1, 3'h2, 3'h3}
      ##1 !cycle_hold_n |=> data_lane_dev_oe;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("advance gave no word");
  property p_burst_end;
    !cycle_hold_n && load_advance && (words_q == 3'h0 || words_q == 3'h4)
      ##1 !cycle_hold_n |=> !data_lane_dev_oe;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("word past burst end");
  property p_hold;
    cycle_hold_n |=> $stable(data_lane_dev_oe) && $stable(data_lane_dev);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved in hold");
  property p_one_driver;
    !(data_lane_dev_oe && data_lane_ctl_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive");
  property p_test_fall;
    $changed(test_dout) || $changed(test_dout_oe) |-> !$past(test_clk);
  endproperty
  a_test_fall: assert property (p_test_fall) else $error("test out not on fall");
endmodule

// File: dv/pipelined_sync_sram_port_tb.sv
// Purpose: Runs the controller end against the device end and checks read data.
// Assumes: Every word read was fully written earlier in the run.
// Notes: mem is updated in issue order, so forwarding is expected too.
`timescale 1ns/10ps
`include "pss_defs.svh"
module pipelined_sync_sram_port_tb;
  localparam int AW = `PSS_ADDR_W;
  localparam int DW = `PSS_LANES * `PSS_LANE_W;
  logic          clk_in;
  logic          arst_n_in;
  logic          req_valid_in;
  logic          req_advance_in;
  logic          req_write_in;
  logic [AW-1:0] req_addr_in;
  logic [DW-1:0] req_wdata_in;
  logic [3:0]    req_byte_write_n_in;
  logic          hold_in;
  logic          order_sel_in;
  logic          test_clk_in;
  logic          test_mode_in;
  logic          test_din_in;
  logic          req_ready_out;
  logic          rsp_valid_out;
  logic [DW-1:0] rsp_rdata_out;
  logic          test_dout_out;
  logic          burst_active_out;
  logic          selected_out;
  logic [DW-1:0] expq [$];
  logic [DW-1:0] mem [logic [AW-1:0]];
  logic [AW-1:0] a;
  logic          b;
  int            mismatches;
  int            n_compared;
  pss_if link ();
  pss_sram_end u_pss_sram_end (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link),
    .burst_active_out(burst_active_out), .selected_out(selected_out));
  pss_ctrl_end u_pss_ctrl_end (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link),
    .req_valid_in(req_valid_in), .req_advance_in(req_advance_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_byte_write_n_in(req_byte_write_n_in), .hold_in(hold_in),
    .order_sel_in(order_sel_in), .test_clk_in(test_clk_in), .test_mode_in(test_mode_in),
    .test_din_in(test_din_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .test_dout_out(test_dout_out));
  pss_port_properties u_pss_port_properties (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .load_advance(link.load_advance), .cycle_hold_n(link.cycle_hold_n),
    .chip_select_low_a(link.chip_select_low_a), .chip_select_pair(link.chip_select_pair),
    .chip_select_low_b(link.chip_select_low_b), .read_write_sel(link.read_write_sel),
    .data_lane_dev(link.data_lane_dev), .data_lane_dev_oe(link.data_lane_dev_oe),
    .data_lane_ctl_oe(link.data_lane_ctl_oe), .test_clk(link.test_clk),
    .test_dout(link.test_dout), .test_dout_oe(link.test_dout_oe));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task results;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk_data(input logic [DW-1:0] act, input logic [DW-1:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t data %h exp %h", $time, act, exp);
    end
  endtask
  task chk_bit(input logic act, input logic exp);
    n_compared++;
    if (act !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t bit %h exp %h", $time, act, exp);
    end
  endtask
  task idle(input int n);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    repeat (n) @(negedge clk_in);
  endtask
  // One load plus n-1 advances; hold is raised before word hk
  task burst(input logic [AW-1:0] ba, input logic wr, input logic full, input int n,
             input int hk);
    logic [AW-1:0] ea;
    logic [DW-1:0] d;
    logic [3:0]    bw;
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk_in);
      ea = {ba[AW-1:2], order_sel_in ? ba[1:0] ^ 2'(k) : ba[1:0] + 2'(k)};
      d = {$urandom(), 4'($urandom())};
      bw = full ? 4'h0 : 4'($urandom());
      req_valid_in = 1'b1;
      req_advance_in = (k != 0);
      req_write_in = wr;
      req_addr_in = (k == 0) ? ba : AW'($urandom());
      req_wdata_in = d;
      req_byte_write_n_in = bw;
      if (k == hk)
      begin
        hold_in = 1'b1;
        repeat (3) @(negedge clk_in);
        chk_bit(req_ready_out, 1'b0);
        chk_bit(burst_active_out, 1'b1);
        chk_bit(selected_out, 1'b1);
        hold_in = 1'b0;
      end
      if (k < 4 && wr)
      begin
        if (!mem.exists(ea))
          mem[ea] = 'x;
        for (int i = 0; i < 4; i++)
          if (!bw[i])
            mem[ea][9*i +: 9] = d[9*i +: 9];
      end
      else if (k < 4)
        expq.push_back(mem[ea]);
    end
  endtask
  always @(negedge clk_in)
  begin
    if (rsp_valid_out === 1'b1)
    begin
      if (expq.size() == 0)
        chk_bit(1'b0, 1'b1);
      else
        chk_data(rsp_rdata_out, expq.pop_front());
    end
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    results();
  end
  initial
  begin
    {req_valid_in, req_advance_in, req_write_in, hold_in, order_sel_in} = 5'h00;
    {test_clk_in, test_mode_in, test_din_in} = 3'h0;
    req_addr_in = '0;
    req_wdata_in = '0;
    req_byte_write_n_in = 4'hF;
    arst_n_in = 1'b0;
    mismatches = 0;
    n_compared = 0;
    void'($urandom(32'h21c1));
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    for (int o = 0; o < 2; o++)
    begin
      order_sel_in = o[0];
      idle(4);
      for (int s = 0; s < 4; s++)
      begin
        a = {(AW-2)'($urandom()), 2'(s)};
        burst(a, 1'b1, 1'b1, 4, -1);
        burst(a, 1'b1, 1'b0, 4, s);
        burst(a, 1'b0, 1'b0, 5, 3 - s);
        burst(a, 1'b0, 1'b0, 2, -1);
        idle(1);
        req_valid_in = 1'b1;
        req_advance_in = 1'b1;
        idle(2);
      end
    end
    for (int t = 0; t < 4; t++)
    begin
      b = 1'($urandom());
      test_din_in = b;
      test_clk_in = 1'b1;
      repeat (10) @(negedge clk_in);
      test_clk_in = 1'b0;
      repeat (10) @(negedge clk_in);
      chk_bit(test_dout_out, b);
    end
    idle(8);
    chk_bit(expq.size() == 0, 1'b1);
    chk_bit(burst_active_out, 1'b0);
    chk_bit(selected_out, 1'b0);
    results();
  end
endmodule
